// ==== verilog/irg_pkg.sv ====
package irg_pkg;
    localparam int CODE_DEPTH = 32;
    localparam int CODE_PTR_W = 5;
    localparam int CODE_CNT_W = 6;
    localparam int REP_DEPTH = 8;
    localparam int REP_PTR_W = 3;
    localparam int REP_CNT_W = 4;
    localparam int WORD_W = 16;
    localparam int TIME_W = 16;
    localparam int TYPE_BIT = 15;
    localparam int LEN_HI = 14;
    localparam int LEN_LO = 11;
    localparam int PAY_HI = 10;
    localparam int SYMBOL_BIT = 14;
    localparam int DUR_HI = 13;
    localparam logic [3:0] MAX_LEN_CODE = 4'ha;
    localparam int CLK_PERIOD_NS = 100;
    localparam int REPEAT_TICK_NS = 102400;
    localparam int REPEAT_TICK_CYCLES = REPEAT_TICK_NS / CLK_PERIOD_NS;
    localparam logic [9:0] REPEAT_TICK_LAST = 10'(REPEAT_TICK_CYCLES - 1);
    localparam int CMD_W = TIME_W + 1;
    localparam logic [CODE_CNT_W-1:0] CODE_CNT_RESET = 6'h00;
    localparam logic [TIME_W-1:0] TIME_RESET = 16'h0000;
    typedef enum logic [2:0] {DEC_IDLE, DEC_FETCH, DEC_FIRST, DEC_SECOND, DEC_PAINT, DEC_DRAIN,
        DEC_REPEAT} irg_dec_state_type;
endpackage

// ==== verilog/irg_generator.sv ====
`timescale 1ns/10ps
module irg_generator (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic carrier_clock_gate_on,
    input wire logic [15:0] carrier_high_time,
    input wire logic [15:0] carrier_low_time,
    input wire logic [15:0] one_mark_time,
    input wire logic [15:0] one_space_time,
    input wire logic [15:0] zero_mark_time,
    input wire logic [15:0] zero_space_time,
    input wire logic one_bit_order_select,
    input wire logic zero_bit_order_select,
    input wire logic time_mode,
    input wire logic invert_output,
    input wire logic key_held,
    input wire logic [15:0] retransmit_interval,
    input wire logic launch_transmission,
    input wire logic code_wr_valid,
    input wire logic [15:0] code_wr_data,
    output logic code_wr_ready,
    input wire logic rep_wr_valid,
    input wire logic [15:0] rep_wr_data,
    output logic rep_wr_ready,
    input wire logic rep_clear,
    output logic [5:0] code_level,
    output logic busy,
    output logic tx_done_irq,
    output logic ir_out
);
    // -------------------------------------------------------------
    // Storage
    // -------------------------------------------------------------
    logic [15:0] code_mem [irg_pkg::CODE_DEPTH];
    logic [15:0] rep_mem [irg_pkg::REP_DEPTH];
    logic [irg_pkg::CMD_W-1:0] buf_mem [2];
    logic [irg_pkg::CODE_PTR_W-1:0] code_wp_reg, code_wp_next, code_rp_reg, code_rp_next;
    logic [irg_pkg::CODE_CNT_W-1:0] code_cnt_reg, code_cnt_next;
    logic [irg_pkg::REP_CNT_W-1:0] rep_cnt_reg, rep_cnt_next;
    // One bit wider than the pointer so a full repeat FIFO still reaches its end mark
    logic [irg_pkg::REP_CNT_W-1:0] rep_idx_reg, rep_idx_next;
    logic [1:0] buf_cnt_reg, buf_cnt_next;
    logic buf_wp_reg, buf_wp_next, buf_rp_reg, buf_rp_next;
    logic code_push, code_pop, rep_push, cmd_valid, cmd_ready, out_valid, out_ready;
    logic [irg_pkg::CMD_W-1:0] cmd_data;
    // -------------------------------------------------------------
    // Decoder state
    // -------------------------------------------------------------
    irg_pkg::irg_dec_state_type dec_reg, dec_next;
    logic [15:0] word_reg, word_next;
    logic [3:0] bit_reg, bit_next;
    logic from_rep_reg, from_rep_next;
    logic [15:0] rep_timer_reg, rep_timer_next;
    logic [9:0] tick_reg, tick_next;
    logic done_reg, done_next;
    // -------------------------------------------------------------
    // Modulator and carrier state
    // -------------------------------------------------------------
    logic mod_active_reg, mod_active_next, mark_reg, mark_next;
    logic [15:0] sym_reg, sym_next, car_cnt_reg, car_cnt_next;
    logic car_level_reg, car_level_next, out_reg, out_next;
    logic cur_bit, first_mark, src_empty;
    logic [15:0] src_word, mark_t, space_t;

    assign code_wr_ready = (code_cnt_reg != 6'(irg_pkg::CODE_DEPTH));
    assign rep_wr_ready = (rep_cnt_reg != 4'(irg_pkg::REP_DEPTH)) && !rep_clear;
    assign code_push = code_wr_valid && code_wr_ready;
    assign rep_push = rep_wr_valid && rep_wr_ready;
    assign code_level = code_cnt_reg;
    assign busy = (dec_reg != irg_pkg::DEC_IDLE);
    assign tx_done_irq = done_reg;
    assign ir_out = out_reg;
    // Two-entry buffer between decoder and modulator; a stalled modulator holds the decoder
    assign cmd_ready = (buf_cnt_reg != 2'h2);
    assign out_valid = (buf_cnt_reg != 2'h0);
    assign out_ready = !mod_active_reg || (sym_reg <= 16'h0001);
    assign src_word = from_rep_reg ? rep_mem[rep_idx_reg[irg_pkg::REP_PTR_W-1:0]] :
        code_mem[code_rp_reg];
    assign src_empty = from_rep_reg ? (rep_idx_reg == rep_cnt_reg) : (code_cnt_reg == 6'h00);
    assign cur_bit = word_reg[bit_reg];
    assign first_mark = cur_bit ? !one_bit_order_select : !zero_bit_order_select;
    assign mark_t = cur_bit ? one_mark_time : zero_mark_time;
    assign space_t = cur_bit ? one_space_time : zero_space_time;

    always_comb
    begin
        dec_next = dec_reg;
        word_next = word_reg;
        bit_next = bit_reg;
        from_rep_next = from_rep_reg;
        rep_timer_next = rep_timer_reg;
        tick_next = tick_reg;
        done_next = 1'b0;
        rep_idx_next = rep_idx_reg;
        cmd_valid = 1'b0;
        cmd_data = '0;
        code_pop = 1'b0;
        unique case (dec_reg)
            irg_pkg::DEC_IDLE:
            begin
                if (launch_transmission && code_cnt_reg != 6'h00)
                begin
                    dec_next = irg_pkg::DEC_FETCH;
                    from_rep_next = 1'b0;
                end
            end
            irg_pkg::DEC_FETCH:
            begin
                if (src_empty)
                    dec_next = irg_pkg::DEC_DRAIN;
                else
                begin
                    word_next = src_word;
                    if (from_rep_reg)
                        rep_idx_next = rep_idx_reg + 4'h1;
                    else
                        code_pop = 1'b1;
                    if (src_word[irg_pkg::TYPE_BIT])
                    begin
                        dec_next = irg_pkg::DEC_FIRST;
                        // Lengths beyond 10 are clipped so the payload field is never overrun
                        bit_next = (src_word[irg_pkg::LEN_HI:irg_pkg::LEN_LO] >
                            irg_pkg::MAX_LEN_CODE) ? irg_pkg::MAX_LEN_CODE :
                            src_word[irg_pkg::LEN_HI:irg_pkg::LEN_LO];
                    end
                    else
                        dec_next = irg_pkg::DEC_PAINT;
                end
            end
            irg_pkg::DEC_PAINT:
            begin
                cmd_valid = 1'b1;
                cmd_data = {word_reg[irg_pkg::SYMBOL_BIT],
                    2'b00, word_reg[irg_pkg::DUR_HI:0]};
                if (cmd_ready)
                    dec_next = irg_pkg::DEC_FETCH;
            end
            irg_pkg::DEC_FIRST:
            begin
                cmd_valid = 1'b1;
                cmd_data = first_mark ? {1'b1, mark_t} : {1'b0, space_t};
                if (cmd_ready)
                    dec_next = irg_pkg::DEC_SECOND;
            end
            irg_pkg::DEC_SECOND:
            begin
                cmd_valid = 1'b1;
                cmd_data = first_mark ? {1'b0, space_t} : {1'b1, mark_t};
                if (cmd_ready)
                begin
                    if (bit_reg == 4'h0)
                        dec_next = irg_pkg::DEC_FETCH;
                    else
                    begin
                        bit_next = bit_reg - 4'h1;
                        dec_next = irg_pkg::DEC_FIRST;
                    end
                end
            end
            irg_pkg::DEC_DRAIN:
            begin
                if (!out_valid && !mod_active_reg)
                begin
                    if (key_held && rep_cnt_reg != 4'h0)
                    begin
                        dec_next = irg_pkg::DEC_REPEAT;
                        rep_timer_next = retransmit_interval;
                        tick_next = 10'h000;
                    end
                    else
                    begin
                        dec_next = irg_pkg::DEC_IDLE;
                        done_next = 1'b1;
                    end
                end
            end
            irg_pkg::DEC_REPEAT:
            begin
                // Interval counts in coarse ticks so a 16-bit value spans protocol periods
                if (!key_held)
                begin
                    dec_next = irg_pkg::DEC_IDLE;
                    done_next = 1'b1;
                end
                else if (tick_reg == irg_pkg::REPEAT_TICK_LAST)
                begin
                    tick_next = 10'h000;
                    if (rep_timer_reg <= 16'h0001)
                    begin
                        dec_next = irg_pkg::DEC_FETCH;
                        from_rep_next = 1'b1;
                        rep_idx_next = 4'h0;
                    end
                    else
                        rep_timer_next = rep_timer_reg - 16'h0001;
                end
                else
                    tick_next = tick_reg + 10'h001;
            end
        endcase
    end

    always_comb
    begin
        code_wp_next = code_push ? code_wp_reg + 5'h01 : code_wp_reg;
        code_rp_next = code_pop ? code_rp_reg + 5'h01 : code_rp_reg;
        code_cnt_next = code_cnt_reg + 6'(code_push) - 6'(code_pop);
        rep_cnt_next = rep_clear ? 4'h0 : rep_cnt_reg + 4'(rep_push);
        buf_wp_next = buf_wp_reg ^ (cmd_valid && cmd_ready);
        buf_rp_next = buf_rp_reg ^ (out_valid && out_ready);
        buf_cnt_next = buf_cnt_reg + 2'(cmd_valid && cmd_ready) - 2'(out_valid && out_ready);
        mod_active_next = mod_active_reg;
        mark_next = mark_reg;
        sym_next = sym_reg;
        if (out_valid && out_ready)
        begin
            mod_active_next = 1'b1;
            mark_next = buf_mem[buf_rp_reg][irg_pkg::CMD_W-1];
            sym_next = buf_mem[buf_rp_reg][irg_pkg::TIME_W-1:0];
        end
        else if (mod_active_reg)
        begin
            if (sym_reg <= 16'h0001)
                mod_active_next = 1'b0;
            else
                sym_next = sym_reg - 16'h0001;
        end
        car_cnt_next = car_cnt_reg;
        car_level_next = car_level_reg;
        if (carrier_clock_gate_on)
        begin
            if (car_cnt_reg >= (car_level_reg ? carrier_high_time : carrier_low_time))
            begin
                car_cnt_next = 16'h0001;
                car_level_next = !car_level_reg;
            end
            else
                car_cnt_next = car_cnt_reg + 16'h0001;
        end
        out_next = (mod_active_reg && mark_reg &&
            (time_mode || car_level_reg)) ^ invert_output;
    end

    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            dec_reg <= irg_pkg::DEC_IDLE;
            word_reg <= 16'h0000;
            bit_reg <= 4'h0;
            from_rep_reg <= 1'b0;
            rep_timer_reg <= irg_pkg::TIME_RESET;
            tick_reg <= 10'h000;
            done_reg <= 1'b0;
            rep_idx_reg <= 4'h0;
            code_wp_reg <= 5'h00;
            code_rp_reg <= 5'h00;
            code_cnt_reg <= irg_pkg::CODE_CNT_RESET;
            rep_cnt_reg <= 4'h0;
            buf_wp_reg <= 1'b0;
            buf_rp_reg <= 1'b0;
            buf_cnt_reg <= 2'h0;
            mod_active_reg <= 1'b0;
            mark_reg <= 1'b0;
            sym_reg <= irg_pkg::TIME_RESET;
            car_cnt_reg <= 16'h0001;
            car_level_reg <= 1'b0;
            out_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            dec_reg <= dec_next;
            word_reg <= word_next;
            bit_reg <= bit_next;
            from_rep_reg <= from_rep_next;
            rep_timer_reg <= rep_timer_next;
            tick_reg <= tick_next;
            done_reg <= done_next;
            rep_idx_reg <= rep_idx_next;
            code_wp_reg <= code_wp_next;
            code_rp_reg <= code_rp_next;
            code_cnt_reg <= code_cnt_next;
            rep_cnt_reg <= rep_cnt_next;
            buf_wp_reg <= buf_wp_next;
            buf_rp_reg <= buf_rp_next;
            buf_cnt_reg <= buf_cnt_next;
            mod_active_reg <= mod_active_next;
            mark_reg <= mark_next;
            sym_reg <= sym_next;
            car_cnt_reg <= car_cnt_next;
            car_level_reg <= car_level_next;
            out_reg <= out_next;
        end
    end

    // -------------------------------------------------------------
    // Word storage, written per entry
    // -------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < irg_pkg::CODE_DEPTH; gi++)
        begin : g_code
            always_ff @(posedge clk_sys)
            begin
                if (clk_en && code_push && code_wp_reg == 5'(gi))
                    code_mem[gi] <= code_wr_data;
            end
        end
        for (gi = 0; gi < irg_pkg::REP_DEPTH; gi++)
        begin : g_rep
            always_ff @(posedge clk_sys)
            begin
                if (clk_en && rep_push && rep_cnt_reg == 4'(gi))
                    rep_mem[gi] <= rep_wr_data;
            end
        end
        for (gi = 0; gi < 2; gi++)
        begin : g_buf
            always_ff @(posedge clk_sys)
            begin
                if (clk_en && cmd_valid && cmd_ready && buf_wp_reg == 1'(gi))
                    buf_mem[gi] <= cmd_data;
            end
        end
    endgenerate

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    fifo_full_refuse_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (code_cnt_reg == 6'h20) |-> !code_wr_ready) else $error("code fifo accepts when full");
    fifo_count_bound_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        code_cnt_reg <= 6'h20) else $error("code fifo count exceeds depth");
    launch_starts_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (clk_en && !busy && launch_transmission && code_cnt_reg != 6'h00) |=> busy)
        else $error("launch did not start transmission");
    type_select_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (clk_en && dec_reg == irg_pkg::DEC_FETCH && !src_empty) |=>
        (dec_reg == (word_reg[15] ? irg_pkg::DEC_FIRST : irg_pkg::DEC_PAINT)))
        else $error("word type not decoded from bit 15");
    length_clip_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (dec_reg == irg_pkg::DEC_FIRST) |-> bit_reg <= 4'ha)
        else $error("bit index beyond payload");
    idle_level_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ($past(clk_en) && !$past(mod_active_reg)) |-> ir_out == $past(invert_output))
        else $error("output not at idle level");
    space_blocks_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ($past(clk_en) && $past(mod_active_reg) && !$past(mark_reg)) |->
        ir_out == $past(invert_output)) else $error("carrier leaked into space");
    time_mode_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ($past(clk_en) && $past(mod_active_reg && mark_reg && time_mode)) |->
        ir_out == !$past(invert_output)) else $error("time mode mark not steady");
    done_pulse_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        tx_done_irq |-> (!busy && $past(busy))) else $error("done without completed transfer");
    buffer_bound_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (buf_cnt_reg == 2'h2) |-> !cmd_ready) else $error("command buffer overrun");

endmodule // irg_generator

// ==== bench/irg_receiver.sv ====
`timescale 1ns/10ps
// ----------------------------------------
// Remote receiver
// ----------------------------------------
// Logs how long each level lasted. Inversion is undone here, so the bench compares
// marks and spaces the same way in either output polarity.
module irg_receiver (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic ir_out,
    input wire logic invert_output
);
    int run_q[$];
    int run_len = 0;
    logic lvl_reg = 1'b0;

    always @(posedge clk_sys)
    begin
        if (arst_n && ((ir_out ^ invert_output) !== lvl_reg))
        begin
            run_q.push_back(run_len);
            run_len = 1;
            lvl_reg = ir_out ^ invert_output;
        end
        else
            run_len++;
    end
endmodule // irg_receiver

// ==== bench/tb_top.sv ====
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch %s expected %0d seen %0d", n, e, g); end end
module tb_top;
    logic clk_sys, arst_n, carrier_clock_gate_on, one_bit_order_select, zero_bit_order_select;
    logic time_mode, invert_output, key_held, launch_transmission, code_wr_valid, rep_wr_valid;
    logic rep_clear, code_wr_ready, rep_wr_ready, busy, tx_done_irq, ir_out;
    logic [15:0] carrier_high_time, carrier_low_time, one_mark_time, one_space_time;
    logic [15:0] zero_mark_time, zero_space_time, retransmit_interval, code_wr_data, rep_wr_data;
    logic [5:0] code_level;
    int bad_count, checked, cyc, last, mx, hi, lo;
    int exp_q[$];
    int got[$];
    logic [15:0] wq[$];
    logic [3:0] len;

    irg_generator i_dut (.clk_sys, .arst_n, .clk_en(1'b1), .carrier_clock_gate_on,
        .carrier_high_time, .carrier_low_time, .one_mark_time, .one_space_time,
        .zero_mark_time, .zero_space_time, .one_bit_order_select, .zero_bit_order_select,
        .time_mode, .invert_output, .key_held, .retransmit_interval, .launch_transmission,
        .code_wr_valid, .code_wr_data, .code_wr_ready, .rep_wr_valid, .rep_wr_data,
        .rep_wr_ready, .rep_clear, .code_level, .busy, .tx_done_irq, .ir_out);
    irg_receiver i_rx (.clk_sys, .arst_n, .ir_out, .invert_output);

    // ----------------------------------------
    // Reference model
    // ----------------------------------------
    // Leading and trailing spaces blend into the idle level, so they are dropped
    task add_sym(input int lv, input int ln);
        if (exp_q.size() == 0 && lv == 0)
            return;
        if (lv == last)
            exp_q[$] += ln;
        else
            exp_q.push_back(ln);
        last = lv;
    endtask

    task model_word(input logic [15:0] w);
        int m;
        int s;
        if (w[15])
        begin
            for (int i = int'(w[14:11]); i >= 0; i--)
            begin
                m = w[i] ? one_mark_time : zero_mark_time;
                s = w[i] ? one_space_time : zero_space_time;
                if (w[i] ? one_bit_order_select : zero_bit_order_select)
                begin
                    add_sym(0, s);
                    add_sym(1, m);
                end
                else
                begin
                    add_sym(1, m);
                    add_sym(0, s);
                end
            end
        end
        else
            add_sym(int'(w[14]), (w[13:0] == 14'h0000) ? 1 : int'(w[13:0]));
    endtask

    // ----------------------------------------
    // Transfers
    // ----------------------------------------
    task complete_run;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Mode 0 compares runs, 1 also overfills the code FIFO, 2 leaves runs to the caller
    task send(input int mode);
        int k;
        exp_q.delete();
        last = 0;
        foreach (wq[i])
            model_word(wq[i]);
        // A closing space never ends in the receiver, it runs on as idle
        if (last == 0 && exp_q.size() > 0)
            void'(exp_q.pop_back());
        i_rx.run_q.delete();
        code_wr_valid <= 1'b1;
        foreach (wq[i])
        begin
            code_wr_data <= wq[i];
            @(posedge clk_sys);
            while (code_wr_ready !== 1'b1)
                @(posedge clk_sys);
        end
        if (mode == 1)
        begin
            code_wr_data <= 16'h7fff;
            repeat (2) @(posedge clk_sys);
            @(negedge clk_sys);
            `CHK("level", 6'h20, code_level);
            `CHK("ready", 1'b0, code_wr_ready);
            @(posedge clk_sys);
        end
        code_wr_valid <= 1'b0;
        @(posedge clk_sys);
        launch_transmission <= 1'b1;
        @(posedge clk_sys);
        launch_transmission <= 1'b0;
        @(negedge clk_sys);
        `CHK("busy", 1'b1, busy);
        k = 0;
        while (tx_done_irq !== 1'b1 && k < 4000)
        begin
            @(negedge clk_sys);
            k++;
        end
        `CHK("done", 1'b1, tx_done_irq);
        `CHK("busy", 1'b0, busy);
        `CHK("level", 6'h00, code_level);
        repeat (4) @(posedge clk_sys);
        got = i_rx.run_q;
        void'(got.pop_front());
        if (mode != 2)
        begin
            `CHK("runs", exp_q.size(), got.size());
            foreach (exp_q[i])
                `CHK("run", exp_q[i], got[i]);
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            bad_count++;
            complete_run();
        end
    end

    initial
    begin
        {arst_n, launch_transmission, code_wr_valid, rep_wr_valid, rep_clear} = 5'h00;
        {one_bit_order_select, zero_bit_order_select, invert_output, key_held} = 4'h0;
        {time_mode, carrier_clock_gate_on} = 2'h3;
        {carrier_high_time, carrier_low_time, retransmit_interval} = {3{16'h0001}};
        {one_mark_time, one_space_time, zero_mark_time, zero_space_time} = {4{16'h0002}};
        {code_wr_data, rep_wr_data} = 32'h00000000;
        repeat (8) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(negedge clk_sys);
        `CHK("level", 6'h00, code_level);
        `CHK("busy", 1'b0, busy);
        `CHK("ready", 1'b1, code_wr_ready);
        `CHK("irq", 1'b0, tx_done_irq);
        void'($urandom(32'hbbc45a2e));
        for (int t = 0; t < 4; t++)
        begin
            @(posedge clk_sys);
            one_bit_order_select <= t[0];
            zero_bit_order_select <= t[1];
            invert_output <= (t == 3);
            // Bit symbols of two cycles or more keep the command buffer ahead of the modulator
            one_mark_time <= 16'($urandom_range(6, 2));
            one_space_time <= 16'($urandom_range(6, 2));
            zero_mark_time <= 16'($urandom_range(6, 2));
            zero_space_time <= 16'($urandom_range(6, 2));
            repeat (4) @(posedge clk_sys);
            `CHK("idle", invert_output, ir_out);
            len = (t == 0) ? 4'ha : (t == 1) ? 4'h0 : 4'($urandom_range(10, 0));
            wq = {{1'b1, len, 11'($urandom)}, {2'h1, 14'($urandom_range(20, 0) * t[1])},
                {2'h0, 14'($urandom_range(9, 1))}, {1'b1, 4'($urandom_range(10, 0)),
                11'($urandom)}};
            send(0);
            $display("test digital %0d done", t);
        end
        invert_output <= 1'b0;
        wq.delete();
        for (int i = 0; i < irg_pkg::CODE_DEPTH; i++)
            wq.push_back({1'b0, 1'(i), 14'(i % 7 + 1)});
        repeat (4) @(posedge clk_sys);
        send(1);
        $display("test fill done");
        time_mode <= 1'b0;
        carrier_high_time <= 16'h0003;
        wq = {16'h4028, 16'h0028, 16'h4028};
        repeat (4) @(posedge clk_sys);
        send(2);
        {mx, hi, lo} = 96'h0;
        foreach (got[i])
        begin
            if (i % 2 == 0)
            begin
                mx = (got[i] > mx) ? got[i] : mx;
                hi += got[i];
            end
            else
                lo = (got[i] > lo) ? got[i] : lo;
        end
        `CHK("carrier high", 3, mx);
        `CHK("mark share", 1, int'(hi >= 55 && hi <= 65));
        `CHK("space gap", 1, int'(lo >= 40));
        $display("test carrier done");
        time_mode <= 1'b1;
        key_held <= 1'b1;
        rep_wr_valid <= 1'b1;
        rep_wr_data <= 16'h4005;
        @(posedge clk_sys);
        while (rep_wr_ready !== 1'b1)
            @(posedge clk_sys);
        rep_wr_valid <= 1'b0;
        fork
            begin
                repeat (1500) @(posedge clk_sys);
                key_held <= 1'b0;
            end
        join_none
        wq = {16'h4005};
        send(2);
        `CHK("repeat runs", 3, got.size());
        `CHK("repeat mark", 5, got[2]);
        `CHK("interval", 1, int'(got[1] >= 1024 && got[1] <= 1060));
        @(posedge clk_sys);
        rep_clear <= 1'b1;
        rep_wr_valid <= 1'b1;
        @(negedge clk_sys);
        `CHK("rep ready", 1'b0, rep_wr_ready);
        @(posedge clk_sys);
        {rep_clear, rep_wr_valid} <= 2'h0;
        $display("test repeat done");
        complete_run();
    end
endmodule // tb_top
